// ==== include/multipurpose_output_port_pkg.sv ====
// Notes on behaviour
// - config bits 1:0 pick output two: latch, tx A x16, tx A x1, rx A x1.
// - config bits 3:2 pick output three: latch, timer output, tx B x1, rx B x1.
// - counter mode timer output is high, low at terminal count, high again on stop.
// - config bit 4 puts inverted channel A receive-ready on output four.
// - config bit 5 puts inverted channel B receive-ready on output five.
// - config bit 6 puts inverted channel A transmit-ready on output six.
// - config bit 7 puts inverted channel B transmit-ready on output seven.
// - every select field resets to zero, so the latch drives outputs two to seven.
// - reading the start strobe starts the timer; read data is meaningless.
// - reading the stop strobe stops the timer; read data is meaningless.
// - set strobe write drives low each latch output whose written bit is one.
// - an output driven low stays low until a clear strobe write releases it.
// - clear strobe write drives high each latch output whose written bit is one.
// - set and clear strobes never touch a pin routed to an alternate function.
// - outputs zero and one go alternate from mode bits, not from config.
// - with request-to-send on output zero, command 0x8 drives low, 0x9 high.
// - in timer mode stop does not halt; it only clears counter-ready.
// - counter start after stop reloads the preload; preload changes wait for it.
package multipurpose_output_port_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register byte addresses
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_STOP = 8'h08;
   localparam logic [7:0] OFS_SET = 8'h0C;
   localparam logic [7:0] OFS_CLEAR = 8'h10;
   localparam logic [7:0] OFS_PINS = 8'h14;
   // reset values
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'hFF;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // field positions
   localparam int SEL_TWO_LSB = 0;
   localparam int SEL_THREE_LSB = 2;
   localparam int PINS_CT_BIT = 8;
   localparam int PINS_CHAN_A_REQUEST_TO_SEND_N_BIT = 9;
   localparam int PINS_RTSB_BIT = 10;
   // status flag positions
   localparam int FLAG_TXA = 0;
   localparam int FLAG_RXA = 1;
   localparam int FLAG_TXB = 4;
   localparam int FLAG_RXB = 5;
   // command codes in bits 7:4
   localparam logic [3:0] CMD_RTS_ASSERT = 4'h8;
   localparam logic [3:0] CMD_RTS_NEGATE = 4'h9;
endpackage

// ==== design/multipurpose_output_port.sv ====
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
module multipurpose_output_port (
   input wire logic sys_clk, // 200 MHz device clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic awvalid, // write address valid
   output logic awready, // write address ready
   input wire logic [multipurpose_output_port_pkg::ADDR_W-1:0] awaddr, // write address
   input wire logic wvalid, // write data valid
   output logic wready, // write data ready
   input wire logic [multipurpose_output_port_pkg::DATA_W-1:0] wdata, // write data
   input wire logic [3:0] wstrb, // byte strobes
   output logic bvalid, // write response valid
   input wire logic bready, // write response ready
   output logic [1:0] bresp, // write response
   input wire logic arvalid, // read address valid
   output logic arready, // read address ready
   input wire logic [multipurpose_output_port_pkg::ADDR_W-1:0] araddr, // read address
   output logic rvalid, // read data valid
   input wire logic rready, // read data ready
   output logic [multipurpose_output_port_pkg::DATA_W-1:0] rdata, // read data
   output logic [1:0] rresp, // read response
   input wire logic [7:0] statusFlags, // interrupt_status flags
   input wire logic chanATxClockX16, // channel A tx 16x clock
   input wire logic chanATxClockX1, // channel A tx 1x clock
   input wire logic chanARxClockX1, // channel A rx 1x clock
   input wire logic chanBTxClockX1, // channel B tx 1x clock
   input wire logic chanBRxClockX1, // channel B rx 1x clock
   input wire logic chanAModeOneRts, // chan_a_mode_one bit 7
   input wire logic chanAModeTwoRts, // chan_a_mode_two bit 5
   input wire logic chanBModeOneRts, // chan_b_mode_one bit 7
   input wire logic chanBModeTwoRts, // chan_b_mode_two bit 5
   input wire logic chanACommandWrite, // chan_a_command written
   input wire logic [7:0] chanACommand, // chan_a_command byte
   input wire logic chanBCommandWrite, // chan_b_command written
   input wire logic [7:0] chanBCommand, // chan_b_command byte
   input wire logic timerMode, // auxiliary_control bit 6
   input wire logic timerTerminal, // counter terminal count pulse
   input wire logic timerWave, // timer square wave
   output logic timerStart, // pulse: start the core
   output logic timerLoad, // pulse: reload preload
   output logic timerHalt, // pulse: halt counter
   output logic timerReadyClear, // pulse: clear counter-ready
   output logic [7:0] outputPins // output_zero to output_seven
);
   import multipurpose_output_port_pkg::*;

   // ***************************************************
   // register bus
   // ***************************************************
   logic wrReady;
   logic [7:0] srcConfig;
   logic [7:0] gpLatch;
   logic ctOut;
   logic ctStopped;
   logic chan_a_request_to_send_n;
   logic rtsB;
   logic wrFire;
   logic rdFire;
   logic [DATA_W-1:0] next_rdata;
   logic rdHit;
   logic wrHit;
   logic wrLow;

   assign awready = wrReady;
   assign wready = wrReady;
   // both channels are taken on one edge, so the write sees address and data together
   assign wrFire = wrReady && awvalid && wvalid;
   assign rdFire = arready && arvalid;
   assign wrLow = wstrb[0];
   assign wrHit = awaddr == OFS_CONFIG || awaddr == OFS_SET || awaddr == OFS_CLEAR;
   assign rdHit = araddr == OFS_CONFIG || araddr == OFS_START || araddr == OFS_STOP
      || araddr == OFS_SET || araddr == OFS_CLEAR || araddr == OFS_PINS;
   // write-only and strobe registers read as zero; only the pin view carries state
   assign next_rdata = (araddr == OFS_PINS) ?
      {21'h000000, rtsB, chan_a_request_to_send_n, ctOut, outputPins} : 32'h00000000;

   // write channel handshake and response
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         wrReady <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         wrReady <= awvalid && wvalid && !wrReady && !bvalid;
         if (wrFire)
         begin
            bvalid <= 1'b1;
            bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
            bvalid <= 1'b0;
      end
   end

   // read channel handshake; one read in flight
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= RESP_OKAY;
      end
      else
      begin
         arready <= arvalid && !arready && !rvalid;
         if (rdFire)
         begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rready)
            rvalid <= 1'b0;
      end
   end

   // ***************************************************
   // configuration and output latch
   // ***************************************************
   logic cfgWrite;
   logic setWrite;
   logic clearWrite;

   assign cfgWrite = wrFire && wrLow && awaddr == OFS_CONFIG;
   assign setWrite = wrFire && wrLow && awaddr == OFS_SET;
   assign clearWrite = wrFire && wrLow && awaddr == OFS_CLEAR;

   // latch keeps moving while a pin is alternate; the pin mux hides it
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         srcConfig <= CONFIG_RESET;
         gpLatch <= LATCH_RESET;
      end
      else
      begin
         if (cfgWrite)
            srcConfig <= wdata[7:0];
         if (setWrite)
            gpLatch <= gpLatch & ~wdata[7:0];
         else if (clearWrite)
            gpLatch <= gpLatch | wdata[7:0];
      end
   end

   // ***************************************************
   // counter/timer control
   // ***************************************************
   logic startFire;
   logic stopFire;

   assign startFire = rdFire && araddr == OFS_START;
   assign stopFire = rdFire && araddr == OFS_STOP;

   // strobes to the core; a stop in timer mode never halts the wave
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         timerStart <= 1'b0;
         timerLoad <= 1'b0;
         timerHalt <= 1'b0;
         timerReadyClear <= 1'b0;
         ctStopped <= 1'b1;
      end
      else
      begin
         timerStart <= startFire;
         timerLoad <= startFire && ctStopped;
         timerHalt <= stopFire && !timerMode;
         timerReadyClear <= stopFire;
         if (stopFire)
            ctStopped <= 1'b1;
         else if (startFire)
            ctStopped <= 1'b0;
      end
   end

   // counter output: high, low at terminal count, high on stop (stop wins)
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         ctOut <= 1'b1;
      else if (timerMode)
         ctOut <= timerWave;
      else if (stopFire)
         ctOut <= 1'b1;
      else if (timerTerminal)
         ctOut <= 1'b0;
   end

   // ***************************************************
   // request-to-send latches
   // ***************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         chan_a_request_to_send_n <= 1'b1;
         rtsB <= 1'b1;
      end
      else
      begin
         if (chanACommandWrite && chanACommand[7:4] == CMD_RTS_ASSERT)
            chan_a_request_to_send_n <= 1'b0;
         else if (chanACommandWrite && chanACommand[7:4] == CMD_RTS_NEGATE)
            chan_a_request_to_send_n <= 1'b1;
         if (chanBCommandWrite && chanBCommand[7:4] == CMD_RTS_ASSERT)
            rtsB <= 1'b0;
         else if (chanBCommandWrite && chanBCommand[7:4] == CMD_RTS_NEGATE)
            rtsB <= 1'b1;
      end
   end

   // ***************************************************
   // pin source selection
   // ***************************************************
   function automatic logic pick4(input logic [1:0] sel, input logic a, input logic b,
      input logic c, input logic d);
      case (sel)
         2'h0: pick4 = a;
         2'h1: pick4 = b;
         2'h2: pick4 = c;
         default: pick4 = d;
      endcase
   endfunction

   // which status flag each of outputs four to seven mirrors
   function automatic int flagOf(input int pin);
      case (pin)
         4: flagOf = FLAG_RXA;
         5: flagOf = FLAG_RXB;
         6: flagOf = FLAG_TXA;
         default: flagOf = FLAG_TXB;
      endcase
   endfunction

   logic [7:0] next_pins;

   // alternate pins ignore the latch; switching back shows the latch next edge
   assign next_pins[0] = (chanAModeOneRts || chanAModeTwoRts) ? chan_a_request_to_send_n : gpLatch[0];
   assign next_pins[1] = (chanBModeOneRts || chanBModeTwoRts) ? rtsB : gpLatch[1];
   assign next_pins[2] = pick4(srcConfig[SEL_TWO_LSB+:2], gpLatch[2], chanATxClockX16,
      chanATxClockX1, chanARxClockX1);
   assign next_pins[3] = pick4(srcConfig[SEL_THREE_LSB+:2], gpLatch[3], ctOut,
      chanBTxClockX1, chanBRxClockX1);

   genvar gi;
   generate
      for (gi = 4; gi < 8; gi++)
      begin : g_flag
         // inverted ready flags
         assign next_pins[gi] = srcConfig[gi] ? ~statusFlags[flagOf(gi)] : gpLatch[gi];
      end
   endgenerate

   // pins are registered so nothing combinational reaches the package
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
         outputPins <= LATCH_RESET;
      else
         outputPins <= next_pins;
   end

   // ***************************************************
   // checks
   // ***************************************************
   property p_cfgDefault;
      @(posedge sys_clk) $past(!rstn) && rstn |-> srcConfig == CONFIG_RESET
         && outputPins == LATCH_RESET;
   endproperty
   a_cfgDefault: assert property (p_cfgDefault) else $error("config not zero after reset");

   property p_setLow;
      @(posedge sys_clk) disable iff (!rstn)
      setWrite |=> (gpLatch & $past(wdata[7:0])) == 8'h00;
   endproperty
   a_setLow: assert property (p_setLow) else $error("set strobe missed a bit");

   property p_clearHigh;
      @(posedge sys_clk) disable iff (!rstn)
      clearWrite |=> (gpLatch & $past(wdata[7:0])) == $past(wdata[7:0]);
   endproperty
   a_clearHigh: assert property (p_clearHigh) else $error("clear strobe missed a bit");

   property p_holdLow;
      @(posedge sys_clk) disable iff (!rstn)
      !clearWrite |=> (~gpLatch & $past(~gpLatch)) == $past(~gpLatch);
   endproperty
   a_holdLow: assert property (p_holdLow) else $error("low output released");

   property p_latchTwo;
      @(posedge sys_clk) disable iff (!rstn)
      srcConfig[1:0] == 2'h0 |=> outputPins[2] == $past(gpLatch[2]);
   endproperty
   a_latchTwo: assert property (p_latchTwo) else $error("output two not on latch");

   property p_rxReadyA;
      @(posedge sys_clk) disable iff (!rstn)
      srcConfig[4] |=> outputPins[4] == !$past(statusFlags[1]);
   endproperty
   a_rxReadyA: assert property (p_rxReadyA) else $error("output four not inverted flag");

   property p_counterLow;
      @(posedge sys_clk) disable iff (!rstn)
      !timerMode && timerTerminal && !stopFire |=> !ctOut ##1 (!ctOut || $past(stopFire)
         || $past(timerMode));
   endproperty
   a_counterLow: assert property (p_counterLow) else $error("counter output not low");

   property p_timerStop;
      @(posedge sys_clk) disable iff (!rstn)
      stopFire && timerMode |=> !timerHalt && timerReadyClear;
   endproperty
   a_timerStop: assert property (p_timerStop) else $error("stop halted the timer");

   property p_start;
      @(posedge sys_clk) disable iff (!rstn)
      startFire |=> timerStart ##1 !timerStart;
   endproperty
   a_start: assert property (p_start) else $error("start strobe not one pulse");

   property p_rtsAssert;
      @(posedge sys_clk) disable iff (!rstn)
      chanACommandWrite && chanACommand[7:4] == CMD_RTS_ASSERT |=> !chan_a_request_to_send_n;
   endproperty
   a_rtsAssert: assert property (p_rtsAssert) else $error("rts not asserted");

   // negate must raise the latch again, or flow control would stall the far end
   property p_rtsNegate;
      @(posedge sys_clk) disable iff (!rstn)
      chanACommandWrite && chanACommand[7:4] == CMD_RTS_NEGATE |=> chan_a_request_to_send_n;
   endproperty
   a_rtsNegate: assert property (p_rtsNegate) else $error("rts not negated");

   property p_rtsPin;
      @(posedge sys_clk) disable iff (!rstn)
      chanAModeOneRts || chanAModeTwoRts |=> outputPins[0] == $past(chan_a_request_to_send_n);
   endproperty
   a_rtsPin: assert property (p_rtsPin) else $error("output zero not on rts");

   property p_routeTimer;
      @(posedge sys_clk) disable iff (!rstn)
      srcConfig[3:2] == 2'h1 |=> outputPins[3] == $past(ctOut);
   endproperty
   a_routeTimer: assert property (p_routeTimer) else $error("output three not on timer");

   property p_stopHigh;
      @(posedge sys_clk) disable iff (!rstn)
      stopFire && !timerMode |=> ctOut;
   endproperty
   a_stopHigh: assert property (p_stopHigh) else $error("counter output not high on stop");

   property p_halt;
      @(posedge sys_clk) disable iff (!rstn)
      stopFire && !timerMode |=> timerHalt;
   endproperty
   a_halt: assert property (p_halt) else $error("stop did not halt the counter");

   property p_load;
      @(posedge sys_clk) disable iff (!rstn)
      startFire && ctStopped |=> timerLoad;
   endproperty
   a_load: assert property (p_load) else $error("fresh start did not reload");

   property p_readyClear;
      @(posedge sys_clk) disable iff (!rstn)
      stopFire |=> timerReadyClear;
   endproperty
   a_readyClear: assert property (p_readyClear) else $error("stop did not clear ready");

   property p_latchSix;
      @(posedge sys_clk) disable iff (!rstn)
      !srcConfig[6] |=> outputPins[6] == $past(gpLatch[6]);
   endproperty
   a_latchSix: assert property (p_latchSix) else $error("output six not on latch");
endmodule

// ==== verif/pin_side_model.sv ====
`timescale 1ns/10ps
// ***************************************
// far side: baud clocks and the timer core
// ***************************************
module pin_side_model (
   input wire logic sys_clk, // device clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic timerMode, // high selects timer mode
   input wire logic timerStart, // start pulse from the port
   input wire logic timerHalt, // halt pulse from the port
   output logic chanATxClockX16, // channel A tx 16x clock
   output logic chanATxClockX1, // channel A tx 1x clock
   output logic chanARxClockX1, // channel A rx 1x clock
   output logic chanBTxClockX1, // channel B tx 1x clock
   output logic chanBRxClockX1, // channel B rx 1x clock
   output logic timerTerminal, // terminal count pulse
   output logic timerWave // square wave level
);
   logic [4:0] divider;
   logic [3:0] count;
   logic running;
   // every clock runs at its own rate, so a wrong select shows up
   assign chanATxClockX16 = divider[0];
   assign chanATxClockX1 = divider[1];
   assign chanARxClockX1 = divider[2];
   assign chanBTxClockX1 = divider[3];
   assign chanBRxClockX1 = divider[4];
   // counter mode stops at terminal count; timer mode keeps toggling
   always_ff @(posedge sys_clk)
   begin
      timerTerminal <= 1'b0;
      if (!rstn)
      begin
         divider <= 5'h00;
         count <= 4'h0;
         running <= 1'b0;
         timerWave <= 1'b1;
      end
      else
      begin
         divider <= divider + 5'h01;
         if (timerStart)
         begin
            running <= 1'b1;
            count <= 4'hB;
         end
         else if (timerHalt)
            running <= 1'b0;
         else if (running && count == 4'h0)
         begin
            count <= 4'h3;
            timerWave <= timerMode ? ~timerWave : timerWave;
            timerTerminal <= ~timerMode;
            running <= timerMode;
         end
         else if (running)
            count <= count - 4'h1;
      end
   end
endmodule

// ==== verif/multipurpose_output_port_tb_top.sv ====
`timescale 1ns/10ps
module multipurpose_output_port_tb_top;
   import multipurpose_output_port_pkg::*;
   logic sys_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr, statusFlags, chanACommand, chanBCommand, outputPins;
   logic [31:0] wdata, rdata, d;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, r;
   logic cAx16, cAx1, cArx, cBx1, cBrx, aRts1, aRts2, bRts1, bRts2, aCw, bCw;
   logic timerMode, timerTerminal, timerWave, tStart, tLoad, tHalt, tClr;
   logic [6:0] srcVec;
   int n_mismatch = 0, compares = 0, cycles = 0;
   int nStart = 0, nLoad = 0, nHalt = 0, nClr = 0;
   multipurpose_output_port multipurpose_output_port_inst (.sys_clk(sys_clk), .rstn(rstn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .statusFlags(statusFlags), .chanATxClockX16(cAx16), .chanATxClockX1(cAx1),
      .chanARxClockX1(cArx), .chanBTxClockX1(cBx1), .chanBRxClockX1(cBrx),
      .chanAModeOneRts(aRts1), .chanAModeTwoRts(aRts2), .chanBModeOneRts(bRts1),
      .chanBModeTwoRts(bRts2), .chanACommandWrite(aCw), .chanACommand(chanACommand),
      .chanBCommandWrite(bCw), .chanBCommand(chanBCommand), .timerMode(timerMode),
      .timerTerminal(timerTerminal), .timerWave(timerWave), .timerStart(tStart),
      .timerLoad(tLoad), .timerHalt(tHalt), .timerReadyClear(tClr),
      .outputPins(outputPins));
   pin_side_model pin_side_model_inst (.sys_clk(sys_clk), .rstn(rstn),
      .timerMode(timerMode), .timerStart(tStart), .timerHalt(tHalt),
      .chanATxClockX16(cAx16), .chanATxClockX1(cAx1), .chanARxClockX1(cArx),
      .chanBTxClockX1(cBx1), .chanBRxClockX1(cBrx), .timerTerminal(timerTerminal),
      .timerWave(timerWave));
   // pin sources by select index: latch (high), baud clocks, timer wave
   assign srcVec = {timerWave, cBrx, cBx1, cArx, cAx1, cAx16, 1'b1};
   // *****************
   // clock and watchdog
   // *****************
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // timer pulses are counted so strobe effects can be checked later
   always @(posedge sys_clk)
   begin
      cycles++;
      nStart += tStart;
      nLoad += tLoad;
      nHalt += tHalt;
      nClr += tClr;
      if (cycles == 20000)
      begin
         n_mismatch++;
         summarize();
      end
   end
   // *****************
   // tasks
   // *****************
   task summarize();
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // address and data are offered together and each released when taken
   task axiWrite(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= v;
      bready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task axiRead(input logic [7:0] a);
      @(posedge sys_clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         if (arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task pins(input logic [7:0] e);
      repeat (3) @(posedge sys_clk);
      #1 chk(outputPins, e);
   endtask
   // the pin is registered, so it trails its source by lag cycles
   task follow(input int b, input logic [7:0] cfg, input int src, input int lag);
      logic e;
      axiWrite(OFS_CONFIG, cfg);
      repeat (4) @(negedge sys_clk);
      repeat (8)
      begin
         e = srcVec[src];
         repeat (lag) @(negedge sys_clk);
         chk(outputPins[b], e);
      end
   endtask
   task cmd(input logic chB, input logic [7:0] c);
      @(posedge sys_clk);
      aCw <= ~chB;
      bCw <= chB;
      chanACommand <= c;
      chanBCommand <= c;
      @(posedge sys_clk);
      aCw <= 1'b0;
      bCw <= 1'b0;
   endtask
   // *****************
   // main sequence
   // *****************
   initial
   begin
      {rstn, awvalid, wvalid, bready, arvalid, rready, aCw, bCw, timerMode} = '0;
      {aRts1, aRts2, bRts1, bRts2} = 4'h0;
      {awaddr, araddr, statusFlags, chanACommand, chanBCommand} = '0;
      wdata = 32'h0;
      wstrb = 4'hF;
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      axiRead(OFS_PINS);
      chk(d, 32'h7FF);
      chk(r, RESP_OKAY);
      // a write with no low byte lane must leave the latch alone
      wstrb <= 4'h0;
      axiWrite(OFS_SET, 32'hFF);
      chk(r, RESP_OKAY);
      wstrb <= 4'hF;
      pins(8'hFF);
      axiWrite(8'h40, 32'hFF);
      chk(r, RESP_SLVERR);
      axiRead(8'h40);
      chk(r, RESP_SLVERR);
      // latch set, a foreign write, then clear
      axiWrite(OFS_SET, 32'hA5);
      pins(8'h5A);
      axiWrite(OFS_CONFIG, 32'h00);
      pins(8'h5A);
      axiWrite(OFS_CLEAR, 32'h0F);
      pins(8'h5F);
      // inverted status flags on outputs four to seven
      axiWrite(OFS_CONFIG, 32'hF0);
      foreach (srcVec[i])
      begin
         statusFlags <= 8'h01 << i;
         @(posedge sys_clk);
         pins({~statusFlags[4], ~statusFlags[0], ~statusFlags[5], ~statusFlags[1], 4'hF});
      end
      axiWrite(OFS_SET, 32'hF0);
      pins({~statusFlags[4], ~statusFlags[0], ~statusFlags[5], ~statusFlags[1], 4'hF});
      axiWrite(OFS_CONFIG, 32'h00);
      pins(8'h0F);
      axiWrite(OFS_CLEAR, 32'hFF);
      for (int i = 0; i < 4; i++)
         follow(2, 8'(i), i, 1);
      follow(3, 8'h08, 4, 1);
      follow(3, 8'h0C, 5, 1);
      // counter mode: low at terminal count, high again on stop
      axiWrite(OFS_CONFIG, 32'h04);
      axiRead(OFS_START);
      pins(8'hFF);
      repeat (30) @(posedge sys_clk);
      pins(8'hF7);
      axiRead(OFS_STOP);
      pins(8'hFF);
      axiRead(OFS_START);
      pins(8'hFF);
      chk({nStart[7:0], nLoad[7:0], nHalt[7:0], nClr[7:0]}, 32'h02020101);
      repeat (30) @(posedge sys_clk);
      pins(8'hF7);
      axiRead(OFS_STOP);
      // timer mode is set and started before the wave is routed
      timerMode <= 1'b1;
      axiWrite(OFS_CONFIG, 32'h00);
      axiRead(OFS_START);
      follow(3, 8'h04, 6, 2);
      axiRead(OFS_STOP);
      repeat (2) @(posedge sys_clk);
      chk({nHalt[7:0], nClr[7:0]}, 32'h0203);
      follow(3, 8'h04, 6, 2);
      // request-to-send on outputs zero and one
      axiWrite(OFS_CONFIG, 32'h00);
      aRts1 <= 1'b1;
      bRts2 <= 1'b1;
      cmd(1'b0, {CMD_RTS_ASSERT, 4'h0});
      pins(8'hFE);
      axiWrite(OFS_SET, 32'h02);
      pins(8'hFE);
      cmd(1'b1, {CMD_RTS_ASSERT, 4'h0});
      pins(8'hFC);
      cmd(1'b0, {CMD_RTS_NEGATE, 4'h0});
      pins(8'hFD);
      axiWrite(OFS_CLEAR, 32'h02);
      pins(8'hFD);
      bRts2 <= 1'b0;
      pins(8'hFF);
      summarize();
   end
endmodule
